//--- rtl/mcuxu_pkg.sv
/*
 * constants, opcode map, carrier types and the adder shared by the
 * execute unit of the 8-bit core and its data memory and return stack.
 * assumes a single 20 MHz clock and a 16-bit instruction word.
 */
// Notes on behaviour
// - add literal to work, flags c dc z
// - destination bit zero to work, one to file
// - add work to file, routed, flags c dc z
// - add work, file and carry, routed, flags
// - pc gets pc plus one plus signed work
// - and literal or file, zero flag only
// - clear or set one file bit, no flags
// - bit test skip discards next fetched instruction
// - call pushes pc plus one, jumps to literal
// - branch loads literal target, two cycles
// - clear file writes zero to addressed byte
// - clear watchdog zeroes counter, sets timeout, power-down
// - decrement file, routed, zero flag only
// - complement file, routed, zero flag only
// - decrement or increment skip when result zero
// - increment file, routed, zero flag only
// - halt stops core until internal or external wake-up
// - or literal or file, zero flag only
// - move file to work, no flags
// - move literal to work, no flags

package mcuxu_pkg;

	// ========================================================
	// widths and reset values
	localparam int PC_W = 13;
	localparam int DATA_W = 8;
	localparam int ADDR_W = 8;
	localparam int DMEM_DEPTH = 256;
	localparam int STACK_DEPTH = 6;
	localparam int WDT_W = 16;
	localparam logic [PC_W-1:0] PC_RESET = 13'h0000;
	localparam logic [PC_W-1:0] PC_STEP = 13'h0001;
	localparam logic [PC_W-1:0] PC_SKIP_STEP = 13'h0002;
	localparam logic [7:0] WORK_RESET = 8'h00;
	localparam logic [15:0] INSTR_RESET = 16'h0000;

	// ========================================================
	// instruction classes, bits 15:13
	localparam logic [2:0] CLS_MISC = 3'h0;
	localparam logic [2:0] CLS_LIT = 3'h1;
	localparam logic [2:0] CLS_FILE = 3'h2;
	localparam logic [2:0] CLS_BIT = 3'h3;
	localparam logic [2:0] CLS_BRANCH = 3'h4;
	localparam logic [2:0] CLS_CALL = 3'h5;

	// literal class codes, bits 12:8, literal in 7:0
	localparam logic [4:0] LIT_ADD = 5'h00;
	localparam logic [4:0] LIT_AND = 5'h01;
	localparam logic [4:0] LIT_OR = 5'h02;
	localparam logic [4:0] LIT_MOVE = 5'h03;

	// file class codes, bits 12:9, destination bit 8, address 7:0
	localparam logic [3:0] FIL_ADD = 4'h0;
	localparam logic [3:0] FIL_ADD_CARRY = 4'h1;
	localparam logic [3:0] FIL_AND = 4'h2;
	localparam logic [3:0] FIL_OR = 4'h3;
	localparam logic [3:0] FIL_DEC = 4'h4;
	localparam logic [3:0] FIL_COMP = 4'h5;
	localparam logic [3:0] FIL_DEC_SKIP = 4'h6;
	localparam logic [3:0] FIL_INC = 4'h7;
	localparam logic [3:0] FIL_INC_SKIP = 4'h8;
	localparam logic [3:0] FIL_MOVE_TO_WORK = 4'h9;
	localparam logic [3:0] FIL_CLEAR = 4'ha;

	// bit class codes, bits 12:11, bit number 10:8, address 7:0
	localparam logic [1:0] BIT_CLEAR = 2'h0;
	localparam logic [1:0] BIT_SET = 2'h1;
	localparam logic [1:0] BIT_SKIP_CLEAR = 2'h2;
	localparam logic [1:0] BIT_SKIP_SET = 2'h3;

	// misc class, whole body
	localparam logic [12:0] MISC_HALT = 13'h0001;
	localparam logic [12:0] MISC_CLEAR_WATCHDOG = 13'h0002;
	localparam logic [12:0] MISC_ADD_WORK_PC = 13'h0003;

	// ========================================================
	// carriers
	typedef struct packed {
		logic [2:0] cls;
		logic [12:0] body;
	} mcuxu_instr_t;

	typedef struct packed {
		logic [7:0] value;
		logic carry;
		logic digit_carry;
	} mcuxu_alu_t;

	typedef enum {
		ST_FETCH,
		ST_EXEC,
		ST_FLUSH_A,
		ST_FLUSH_B,
		ST_HALT
	} mcuxu_state_t;

	// ========================================================
	// adder with carry out of bits 3 and 7
	function automatic mcuxu_alu_t mcuxu_add8(input logic [7:0] a, input logic [7:0] b,
		input logic cin);
		logic [4:0] lo;
		logic [8:0] full;
		mcuxu_alu_t r;
		lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
		full = {1'b0, a} + {1'b0, b} + {8'h00, cin};
		r.value = full[7:0];
		r.carry = full[8];
		r.digit_carry = lo[4];
		return r;
	endfunction

endpackage

//--- rtl/mcuxu_data_ram.sv
/*
 * data memory of the core: one write port, one read port.
 * read data come out of a register one clock after the address.
 */
`timescale 1ns/1ps
`default_nettype none

module mcuxu_data_ram import mcuxu_pkg::*; #(
	parameter int DEPTH = DMEM_DEPTH,
	parameter int WIDTH = DATA_W
) (
	input wire logic i_clk,
	input wire logic [ADDR_W-1:0] i_raddr,
	input wire logic i_we,
	input wire logic [ADDR_W-1:0] i_waddr,
	input wire logic [WIDTH-1:0] i_wdata,
	output logic [WIDTH-1:0] o_rdata
);

	// ========================================================
	// storage
	// contents are undefined after reset, as on the real part
	logic [WIDTH-1:0] mem [DEPTH];

	if (DEPTH != (1 << ADDR_W)) begin : g_depth_check
		$error("data memory depth must cover the full file address range");
	end

	always_ff @(posedge i_clk) begin
		if (i_we) begin
			mem[i_waddr] <= i_wdata;
		end
		o_rdata <= mem[i_raddr];
	end

endmodule

`default_nettype wire

//--- rtl/mcuxu_ret_stack.sv
/*
 * return address stack of the core, push only in this unit.
 * a push beyond the depth overwrites the oldest entry.
 */
`timescale 1ns/1ps
`default_nettype none

module mcuxu_ret_stack import mcuxu_pkg::*; #(
	parameter int DEPTH = STACK_DEPTH
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_push,
	input wire logic [PC_W-1:0] i_data,
	output logic [PC_W-1:0] o_top_ff
);

	// ========================================================
	// storage and pointer
	localparam int PTR_W = $clog2(DEPTH);
	logic [PC_W-1:0] slot_ff [DEPTH];
	logic [PTR_W-1:0] ptr_ff;
	logic [PTR_W-1:0] nxt_ptr;
	logic [PC_W-1:0] nxt_top;

	if (DEPTH < 2) begin : g_depth_check
		$error("return stack needs at least two entries");
	end

	always_comb begin
		nxt_ptr = ptr_ff;
		nxt_top = o_top_ff;
		if (i_push) begin
			nxt_top = i_data;
			nxt_ptr = (ptr_ff == PTR_W'(DEPTH - 1)) ? '0 : ptr_ff + 1'b1;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ptr_ff <= '0;
			o_top_ff <= PC_RESET;
		end else begin
			ptr_ff <= nxt_ptr;
			o_top_ff <= nxt_top;
		end
	end

	// entries hold no reset value; only the pointer and the top register are defined
	always_ff @(posedge i_clk) begin
		if (i_push) begin
			slot_ff[ptr_ff] <= i_data;
		end
	end

endmodule

`default_nettype wire

//--- rtl/mcuxu_core.sv
/*
 * execute unit of the 8-bit core: fetch, decode and execute of the
 * arithmetic, logic, bit, move, skip, branch, call, watchdog and halt
 * instructions. assumes program memory answers the address on
 * O_PROG_ADDR with its word on I_PROG_DATA within one clock.
 */
`timescale 1ns/1ps
`default_nettype none

module mcuxu_core import mcuxu_pkg::*; #(
	parameter int WDT_WIDTH = WDT_W
) (
	input wire logic I_SYS_CLK,
	input wire logic I_RST_N,
	input wire logic [15:0] I_PROG_DATA,
	input wire logic I_WAKE_INT,
	input wire logic I_WAKE_EXT,
	output logic [PC_W-1:0] O_PROG_ADDR,
	output logic [DATA_W-1:0] O_WORK,
	output logic O_CARRY,
	output logic O_DIGIT_CARRY,
	output logic O_ZERO,
	output logic O_TIMEOUT_FLAG,
	output logic O_POWER_DOWN_FLAG,
	output logic O_HALTED,
	output logic [PC_W-1:0] O_STACK_TOP
);

	if (WDT_WIDTH < 2) begin : g_wdt_check
		$error("watchdog counter too narrow");
	end

	// ========================================================
	// state
	mcuxu_state_t state_ff, nxt_state;
	mcuxu_instr_t ir_ff, nxt_ir;
	logic [PC_W-1:0] pc_ff, nxt_pc;
	logic [7:0] work_ff, nxt_work;
	logic carry_ff, nxt_carry;
	logic digit_carry_ff, nxt_digit_carry;
	logic zero_ff, nxt_zero;
	logic timeout_flag_ff, nxt_timeout_flag;
	logic power_down_flag_ff, nxt_power_down_flag;
	logic halted_ff, nxt_halted;
	logic [WDT_WIDTH-1:0] watchdog_counter_ff, nxt_watchdog_counter;

	// ========================================================
	// execute datapath signals
	logic [7:0] file_rdata;
	logic [7:0] lit;
	logic [7:0] bit_mask;
	logic file_bit;
	mcuxu_alu_t res;
	logic upd_carries;
	logic upd_zero;
	logic to_work;
	logic to_file;
	logic skip;
	logic wdt_clear;
	logic mem_we;
	logic stack_push;
	logic [ADDR_W-1:0] mem_raddr;

	assign lit = ir_ff.body[7:0];
	assign bit_mask = 8'h01 << ir_ff.body[10:8];
	assign file_bit = |(file_rdata & bit_mask);
	// the read is launched from the word being fetched so data is ready in exec
	assign mem_raddr = I_PROG_DATA[ADDR_W-1:0];

	// ========================================================
	// instruction sequencing and execution
	always_comb begin
		nxt_state = state_ff;
		nxt_ir = ir_ff;
		nxt_pc = pc_ff;
		nxt_work = work_ff;
		nxt_carry = carry_ff;
		nxt_digit_carry = digit_carry_ff;
		nxt_zero = zero_ff;
		res = '{value: file_rdata, carry: 1'b0, digit_carry: 1'b0};
		upd_carries = 1'b0;
		upd_zero = 1'b0;
		to_work = 1'b0;
		to_file = 1'b0;
		skip = 1'b0;
		wdt_clear = 1'b0;
		stack_push = 1'b0;
		unique case (state_ff)
			ST_FETCH: begin
				nxt_ir = mcuxu_instr_t'(I_PROG_DATA);
				nxt_state = ST_EXEC;
			end
			ST_EXEC: begin
				nxt_state = ST_FETCH;
				nxt_pc = pc_ff + PC_STEP;
				unique case (ir_ff.cls)
					CLS_LIT: begin
						to_work = 1'b1;
						upd_zero = 1'b1;
						case (ir_ff.body[12:8])
							LIT_ADD: begin
								res = mcuxu_add8(work_ff, lit, 1'b0);
								upd_carries = 1'b1;
							end
							LIT_AND: res.value = work_ff & lit;
							LIT_OR: res.value = work_ff | lit;
							LIT_MOVE: begin
								res.value = lit;
								upd_zero = 1'b0;
							end
							default: begin
								to_work = 1'b0;
								upd_zero = 1'b0;
							end
						endcase
					end
					CLS_FILE: begin
						to_work = ~ir_ff.body[8];
						to_file = ir_ff.body[8];
						upd_zero = 1'b1;
						case (ir_ff.body[12:9])
							FIL_ADD: begin
								res = mcuxu_add8(work_ff, file_rdata, 1'b0);
								upd_carries = 1'b1;
							end
							FIL_ADD_CARRY: begin
								res = mcuxu_add8(work_ff, file_rdata, carry_ff);
								upd_carries = 1'b1;
							end
							FIL_AND: res.value = work_ff & file_rdata;
							FIL_OR: res.value = work_ff | file_rdata;
							FIL_DEC: res.value = file_rdata - 8'h01;
							FIL_COMP: res.value = ~file_rdata;
							FIL_INC: res.value = file_rdata + 8'h01;
							FIL_DEC_SKIP: begin
								res.value = file_rdata - 8'h01;
								upd_zero = 1'b0;
								skip = (res.value == 8'h00);
							end
							FIL_INC_SKIP: begin
								res.value = file_rdata + 8'h01;
								upd_zero = 1'b0;
								skip = (res.value == 8'h00);
							end
							FIL_MOVE_TO_WORK: begin
								to_work = 1'b1;
								to_file = 1'b0;
								upd_zero = 1'b0;
							end
							FIL_CLEAR: begin
								res.value = 8'h00;
								to_work = 1'b0;
								to_file = 1'b1;
								upd_zero = 1'b0;
							end
							default: begin
								to_work = 1'b0;
								to_file = 1'b0;
								upd_zero = 1'b0;
							end
						endcase
					end
					CLS_BIT: begin
						unique case (ir_ff.body[12:11])
							BIT_CLEAR: begin
								res.value = file_rdata & ~bit_mask;
								to_file = 1'b1;
							end
							BIT_SET: begin
								res.value = file_rdata | bit_mask;
								to_file = 1'b1;
							end
							BIT_SKIP_CLEAR: skip = ~file_bit;
							BIT_SKIP_SET: skip = file_bit;
						endcase
					end
					CLS_BRANCH: begin
						nxt_pc = ir_ff.body[PC_W-1:0];
						nxt_state = ST_FLUSH_A;
					end
					CLS_CALL: begin
						stack_push = 1'b1;
						nxt_pc = ir_ff.body[PC_W-1:0];
						nxt_state = ST_FLUSH_A;
					end
					CLS_MISC: begin
						case (ir_ff.body)
							MISC_HALT: nxt_state = ST_HALT;
							MISC_CLEAR_WATCHDOG: wdt_clear = 1'b1;
							MISC_ADD_WORK_PC: begin
								// sign extension is the same as subtracting 100h at and above 80h
								nxt_pc = pc_ff + PC_STEP + {{(PC_W-8){work_ff[7]}}, work_ff};
								nxt_state = ST_FLUSH_A;
							end
							default: nxt_state = ST_FETCH;
						endcase
					end
					default: nxt_state = ST_FETCH;
				endcase
				if (skip) begin
					nxt_pc = pc_ff + PC_SKIP_STEP;
					nxt_state = ST_FLUSH_A;
				end
				if (to_work) begin
					nxt_work = res.value;
				end
				if (upd_carries) begin
					nxt_carry = res.carry;
					nxt_digit_carry = res.digit_carry;
				end
				if (upd_zero) begin
					nxt_zero = (res.value == 8'h00);
				end
			end
			// the discarded slot costs a full instruction cycle of two clocks
			ST_FLUSH_A: nxt_state = ST_FLUSH_B;
			ST_FLUSH_B: nxt_state = ST_FETCH;
			ST_HALT: begin
				if (I_WAKE_INT || I_WAKE_EXT) begin
					nxt_state = ST_FETCH;
				end
			end
		endcase
		nxt_halted = (nxt_state == ST_HALT);
	end

	assign mem_we = (state_ff == ST_EXEC) && to_file;

	always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			state_ff <= ST_FETCH;
			ir_ff <= mcuxu_instr_t'(INSTR_RESET);
			pc_ff <= PC_RESET;
			work_ff <= WORK_RESET;
			carry_ff <= 1'b0;
			digit_carry_ff <= 1'b0;
			zero_ff <= 1'b0;
			halted_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			ir_ff <= nxt_ir;
			pc_ff <= nxt_pc;
			work_ff <= nxt_work;
			carry_ff <= nxt_carry;
			digit_carry_ff <= nxt_digit_carry;
			zero_ff <= nxt_zero;
			halted_ff <= nxt_halted;
		end
	end

	// ========================================================
	// watchdog, keeps counting while halted since the oscillator runs
	always_comb begin
		nxt_watchdog_counter = watchdog_counter_ff + 1'b1;
		nxt_timeout_flag = timeout_flag_ff;
		nxt_power_down_flag = power_down_flag_ff;
		if (&watchdog_counter_ff) begin
			nxt_timeout_flag = 1'b0;
		end
		// a clear in the overflow cycle wins so the flag is not dropped
		if (wdt_clear) begin
			nxt_watchdog_counter = '0;
			nxt_timeout_flag = 1'b1;
			nxt_power_down_flag = 1'b1;
		end
	end

	always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			watchdog_counter_ff <= '0;
			timeout_flag_ff <= 1'b1;
			power_down_flag_ff <= 1'b1;
		end else begin
			watchdog_counter_ff <= nxt_watchdog_counter;
			timeout_flag_ff <= nxt_timeout_flag;
			power_down_flag_ff <= nxt_power_down_flag;
		end
	end

	// ========================================================
	// memories
	mcuxu_data_ram #(
		.DEPTH(DMEM_DEPTH),
		.WIDTH(DATA_W)
	) u_data_ram (
		.i_clk(I_SYS_CLK),
		.i_raddr(mem_raddr),
		.i_we(mem_we),
		.i_waddr(ir_ff.body[ADDR_W-1:0]),
		.i_wdata(res.value),
		.o_rdata(file_rdata)
	);

	mcuxu_ret_stack #(
		.DEPTH(STACK_DEPTH)
	) u_ret_stack (
		.i_clk(I_SYS_CLK),
		.i_rst_n(I_RST_N),
		.i_push(stack_push),
		.i_data(pc_ff + PC_STEP),
		.o_top_ff(O_STACK_TOP)
	);

	assign O_PROG_ADDR = pc_ff;
	assign O_WORK = work_ff;
	assign O_CARRY = carry_ff;
	assign O_DIGIT_CARRY = digit_carry_ff;
	assign O_ZERO = zero_ff;
	assign O_TIMEOUT_FLAG = timeout_flag_ff;
	assign O_POWER_DOWN_FLAG = power_down_flag_ff;
	assign O_HALTED = halted_ff;

endmodule

`default_nettype wire

//--- test/mcuxu_core_assertions.sv
/*
 * port assertions of the execute unit, bound to every core instance.
 * assumes one clock and the asynchronous active-low reset.
 */
`timescale 1ns/1ps
`default_nettype none

module mcuxu_core_assertions import mcuxu_pkg::*; #(
	parameter int WDT_WIDTH = WDT_W
) (
	input wire logic I_SYS_CLK,
	input wire logic I_RST_N,
	input wire logic [15:0] I_PROG_DATA,
	input wire logic I_WAKE_INT,
	input wire logic I_WAKE_EXT,
	input wire logic [PC_W-1:0] O_PROG_ADDR,
	input wire logic [DATA_W-1:0] O_WORK,
	input wire logic O_CARRY,
	input wire logic O_DIGIT_CARRY,
	input wire logic O_ZERO,
	input wire logic O_TIMEOUT_FLAG,
	input wire logic O_POWER_DOWN_FLAG,
	input wire logic O_HALTED,
	input wire logic [PC_W-1:0] O_STACK_TOP
);
	default clocking cb @(posedge I_SYS_CLK);
	endclocking
	default disable iff (!I_RST_N);

	// ========================================================
	// halt and wake
	AST_HALT_HOLDS: assert property (
		O_HALTED && !I_WAKE_INT && !I_WAKE_EXT |=> O_HALTED && $stable(O_PROG_ADDR))
		else $error("halt left or pc moved without wake");
	AST_HALT_WAKE: assert property (
		O_HALTED && (I_WAKE_INT || I_WAKE_EXT) |=> !O_HALTED)
		else $error("wake request did not end halt");
	AST_HALT_ENTRY: assert property (
		$rose(O_HALTED) |-> O_PROG_ADDR == $past(O_PROG_ADDR) + PC_STEP)
		else $error("halt entry pc not next address");
	AST_HALT_FROZEN: assert property (
		O_HALTED |=> $stable({O_WORK, O_CARRY, O_DIGIT_CARRY, O_ZERO, O_STACK_TOP}))
		else $error("state changed while halted");

	// ========================================================
	// watchdog flags, call and commit points
	AST_WDT_CLEAR: assert property (
		$rose(O_TIMEOUT_FLAG) |-> O_POWER_DOWN_FLAG && $changed(O_PROG_ADDR))
		else $error("timeout flag rose outside a watchdog clear");
	AST_PD_HIGH: assert property (O_POWER_DOWN_FLAG)
		else $error("power-down flag low");
	AST_CALL_PUSH: assert property (
		$changed(O_STACK_TOP) |-> O_STACK_TOP == $past(O_PROG_ADDR) + PC_STEP)
		else $error("pushed address not pc plus one");
	AST_WORK_COMMIT: assert property (
		$changed(O_WORK) |-> $changed(O_PROG_ADDR))
		else $error("work changed off an instruction commit");
	AST_FLAG_COMMIT: assert property (
		$changed({O_CARRY, O_DIGIT_CARRY, O_ZERO}) |-> $changed(O_PROG_ADDR) && !$past(O_HALTED))
		else $error("flags changed off an instruction commit");
	AST_ZERO_MATCH: assert property (
		$changed(O_WORK) && $changed(O_ZERO) |-> O_ZERO == (O_WORK == 8'h00))
		else $error("zero flag disagrees with work result");
endmodule

bind mcuxu_core mcuxu_core_assertions #(
	.WDT_WIDTH(WDT_WIDTH)
) u_mcuxu_core_assertions (
	.I_SYS_CLK(I_SYS_CLK),
	.I_RST_N(I_RST_N),
	.I_PROG_DATA(I_PROG_DATA),
	.I_WAKE_INT(I_WAKE_INT),
	.I_WAKE_EXT(I_WAKE_EXT),
	.O_PROG_ADDR(O_PROG_ADDR),
	.O_WORK(O_WORK),
	.O_CARRY(O_CARRY),
	.O_DIGIT_CARRY(O_DIGIT_CARRY),
	.O_ZERO(O_ZERO),
	.O_TIMEOUT_FLAG(O_TIMEOUT_FLAG),
	.O_POWER_DOWN_FLAG(O_POWER_DOWN_FLAG),
	.O_HALTED(O_HALTED),
	.O_STACK_TOP(O_STACK_TOP)
);

`default_nettype wire

//--- test/mcuxu_prog_rom.sv
/*
 * program memory model: answers the word at the fetch address at once.
 * assumes the bench fills it before reset ends.
 */
`timescale 1ns/1ps
`default_nettype none

module mcuxu_prog_rom import mcuxu_pkg::*; (
	input wire logic [PC_W-1:0] i_addr,
	output logic [15:0] o_data
);
	// ========================================================
	// storage; unfilled words are no-operations, so stray fetches stay harmless
	logic [15:0] mem [0:8191] = '{default: 16'h0000};

	assign o_data = mem[i_addr];
endmodule

`default_nettype wire

//--- test/mcuxu_core_tb.sv
/*
 * self-checking bench of the execute unit: a straight table program,
 * then skips, jumps, a call, two halts and a reset in mid-run.
 * assumes the program memory model.
 */
`timescale 1ns/1ps
`default_nettype none

module mcuxu_core_tb import mcuxu_pkg::*;;
	logic I_SYS_CLK = 1'b0;
	logic I_RST_N = 1'b0;
	logic I_WAKE_INT = 1'b0;
	logic I_WAKE_EXT = 1'b0;
	logic [15:0] I_PROG_DATA;
	logic [PC_W-1:0] O_PROG_ADDR, O_STACK_TOP;
	logic [7:0] O_WORK;
	logic O_CARRY, O_DIGIT_CARRY, O_ZERO, O_TIMEOUT_FLAG, O_POWER_DOWN_FLAG, O_HALTED;
	int err_total = 0;
	int n_checks = 0;
	// word, then expected work and {carry, digit carry, zero}
	localparam logic [31:0] ROWS [24] = '{
		32'h2308_0800, 32'h2008_1002, 32'h20f0_0005, 32'h23c2_c205,
		32'h5420_c205, 32'h4120_c200, 32'h2317_1700, 32'h4020_d900,
		32'h4120_d904, 32'h4220_7506, 32'h215f_5506, 32'h4420_1106,
		32'h2100_0007, 32'h4620_9b06, 32'h2285_9f06, 32'h4a20_6406,
		32'h4920_6406, 32'h4e20_9b06, 32'h6120_9b06, 32'h6820_9b06,
		32'h5220_9906, 32'h2067_0007, 32'h5220_9907, 32'h0002_9907};
	// address, word
	localparam logic [31:0] HAND [16] = '{
		32'h0018_7820, 32'h0019_2300, 32'h001a_7020, 32'h001b_5421,
		32'h001c_4b21, 32'h001d_5021, 32'h001e_2355, 32'h001f_4d21,
		32'h0020_8100, 32'h0100_2303, 32'h0101_0003, 32'h0102_bffe,
		32'h0105_23fb, 32'h0106_0003, 32'h1fff_0001, 32'h1ffe_0001};

	always #25 I_SYS_CLK = ~I_SYS_CLK;

	// ========================================================
	// design and program memory
	mcuxu_core #(.WDT_WIDTH(4)) u_mcuxu_core (
		.I_SYS_CLK(I_SYS_CLK),
		.I_RST_N(I_RST_N),
		.I_PROG_DATA(I_PROG_DATA),
		.I_WAKE_INT(I_WAKE_INT),
		.I_WAKE_EXT(I_WAKE_EXT),
		.O_PROG_ADDR(O_PROG_ADDR),
		.O_WORK(O_WORK),
		.O_CARRY(O_CARRY),
		.O_DIGIT_CARRY(O_DIGIT_CARRY),
		.O_ZERO(O_ZERO),
		.O_TIMEOUT_FLAG(O_TIMEOUT_FLAG),
		.O_POWER_DOWN_FLAG(O_POWER_DOWN_FLAG),
		.O_HALTED(O_HALTED),
		.O_STACK_TOP(O_STACK_TOP)
	);
	mcuxu_prog_rom u_mcuxu_prog_rom (
		.i_addr(O_PROG_ADDR),
		.o_data(I_PROG_DATA)
	);

	// ========================================================
	// checking and ending
	task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// reset values: pc, work, flags and stack top zero, timeout and power-down set
	task automatic chk_reset(input string name);
		chk(name, {O_WORK, O_CARRY, O_DIGIT_CARRY, O_ZERO, O_TIMEOUT_FLAG, O_POWER_DOWN_FLAG,
			O_HALTED, 2'h0}, 16'h0018);
		chk({name, " pc"}, {O_PROG_ADDR, 3'h0}, 16'h0000);
		chk({name, " stack"}, {3'h0, O_STACK_TOP}, 16'h0000);
	endtask

	// one instruction cycle is two clocks; the pc settles just after the edge
	task automatic step(input int n, input logic [PC_W-1:0] pc);
		repeat (n) @(posedge I_SYS_CLK);
		#1;
		chk("pc", {3'h0, O_PROG_ADDR}, {3'h0, pc});
	endtask

	task automatic tally_and_finish();
		$display("checks %0d errors %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	initial begin
		#100us;
		err_total++;
		tally_and_finish();
	end

	// ========================================================
	// main sequence
	initial begin
		#1;
		foreach (ROWS[i]) u_mcuxu_prog_rom.mem[i] = ROWS[i][31:16];
		foreach (HAND[j]) u_mcuxu_prog_rom.mem[HAND[j][28:16]] = HAND[j][15:0];
		repeat (5) @(posedge I_SYS_CLK);
		#1;
		chk_reset("reset");
		repeat (5) @(posedge I_SYS_CLK);
		I_RST_N <= 1'b1;
		for (int i = 0; i < 24; i++) begin
			step(2, PC_W'(i + 1));
			chk("work", {8'h00, O_WORK}, {8'h00, ROWS[i][15:8]});
			chk("flags", {13'h0, O_CARRY, O_DIGIT_CARRY, O_ZERO}, {13'h0, ROWS[i][2:0]});
			if (ROWS[i][31:16] == 16'h0002) begin
				chk("wdt", {14'h0, O_TIMEOUT_FLAG, O_POWER_DOWN_FLAG}, 16'h0003);
			end
		end
		// skips: taken bit test, untaken bit test, increment and decrement skips
		step(2, 13'h001a);
		step(4, 13'h001b);
		chk("skip work", {8'h00, O_WORK}, 16'h0099);
		step(2, 13'h001c);
		step(2, 13'h001d);
		step(2, 13'h001f);
		chk("inc skip", {O_WORK, 7'h00, O_ZERO}, 16'h0000);
		step(4, 13'h0020);
		chk("dec skip", {8'h00, O_WORK}, 16'h0000);
		// branch, relative jumps both ways, call to the address below the top
		step(2, 13'h0100);
		step(4, 13'h0101);
		step(2, 13'h0105);
		step(4, 13'h0106);
		step(2, 13'h0102);
		step(4, 13'h1ffe);
		chk("stack", {3'h0, O_STACK_TOP}, 16'h0103);
		// two halts at the top: the external request wakes the first, the internal one
		// the second, whose next address wraps to zero
		step(4, 13'h1fff);
		chk("halted", {15'h0, O_HALTED}, 16'h0001);
		step(20, 13'h1fff);
		chk("halt wdt", {14'h0, O_HALTED, O_TIMEOUT_FLAG}, 16'h0002);
		@(posedge I_SYS_CLK);
		I_WAKE_EXT <= 1'b1;
		step(1, 13'h1fff);
		chk("woken ext", {15'h0, O_HALTED}, 16'h0000);
		@(posedge I_SYS_CLK);
		I_WAKE_EXT <= 1'b0;
		step(1, 13'h0000);
		chk("halted again", {15'h0, O_HALTED}, 16'h0001);
		@(posedge I_SYS_CLK);
		I_WAKE_INT <= 1'b1;
		step(1, 13'h0000);
		chk("woken int", {15'h0, O_HALTED}, 16'h0000);
		// a reset in mid-run restores every output and restarts at address zero
		@(posedge I_SYS_CLK);
		I_RST_N <= 1'b0;
		I_WAKE_INT <= 1'b0;
		repeat (2) @(posedge I_SYS_CLK);
		#1;
		chk_reset("rerun");
		@(posedge I_SYS_CLK);
		I_RST_N <= 1'b1;
		step(2, 13'h0001);
		chk("rerun work", {8'h00, O_WORK}, {8'h00, ROWS[0][15:8]});
		tally_and_finish();
	end
endmodule

`default_nettype wire
